// ===== core/seat_pkg.sv
// Shared constants for the sensor enable and light timing block
package seat_pkg;
	// Register indices; the byte address is four times the index
	localparam int ADDR_W = 10;
	localparam logic [7:0] IDX_FUNC_EN = 8'h80;
	localparam logic [7:0] IDX_ALS_INTEGRATION_TIME = 8'h81;
	localparam logic [7:0] IDX_IRQ_ST = 8'hE0;
	localparam logic [7:0] IDX_IRQ_EN = 8'hE1;
	localparam logic [7:0] IDX_IRQ_CLR = 8'hE2;
	localparam logic [7:0] IDX_ENG_ST = 8'hE3;
	localparam logic [7:0] IDX_ALS_RES = 8'hE4;
	// Function enable bit positions
	localparam int B_PON = 0;
	localparam int B_LIGHT = 1;
	localparam int B_PROX = 2;
	localparam int B_WAIT = 3;
	localparam int B_LIRQ = 4;
	localparam int B_PIRQ = 5;
	localparam int B_GEST = 6;
	localparam int B_BEAM = 7;
	// Reset values and the bits that survive a power-off write
	localparam logic [7:0] FUNC_EN_RST = 8'h00;
	localparam logic [7:0] ALS_INTEGRATION_TIME_RST = 8'hFF;
	localparam logic [7:0] PWR_OFF_KEEP = 8'h79;
	// Integration span and saturation
	localparam logic [8:0] ALS_INTEGRATION_TIME_SPAN = 9'h100;
	localparam logic [15:0] SAT_MAX = 16'hFFFF;
	localparam int SAT_SHIFT = 10;
	localparam logic [8:0] SAT_CYC_LIM = 9'h040;
	// Sticky event bits
	localparam int EV_N = 4;
	localparam int EV_DONE = 0;
	localparam int EV_LIRQ = 1;
	localparam int EV_PIRQ = 2;
	localparam int EV_GEST = 3;
	// Base tick of the internal oscillator
	localparam real BASE_TICK_MS = 2.78;
	localparam real CLK_MHZ = 20.0;
	localparam int TICK_CYCLES = int'(BASE_TICK_MS * 1000.0 * CLK_MHZ);
endpackage : seat_pkg

// ===== core/seat_tick.sv
// Base tick generator that runs only while the oscillator is on
`timescale 1ns/100ps
module seat_tick import seat_pkg::*; #(
	parameter int TICK_CYC = TICK_CYCLES
) (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic run,
	output logic tick
);
	typedef struct packed {
		logic [31:0] cnt;
		logic tick;
	} seat_tick_st_t;
	seat_tick_st_t s_q;
	seat_tick_st_t s_d;

	// Count one base period; a stopped oscillator restarts from zero
	always_comb begin
		s_d = s_q;
		s_d.tick = 1'b0;
		if (!run) begin
			s_d.cnt = '0;
		end else if (s_q.cnt == 32'(TICK_CYC - 1)) begin
			s_d.cnt = '0;
			s_d.tick = 1'b1;
		end else begin
			s_d.cnt = s_q.cnt + 32'h0000_0001;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign tick = s_q.tick;

	a_tick_needs_osc: assert property (@(posedge clock) disable iff (!arst_n)
		s_q.tick |-> $past(run) && s_q.cnt == '0)
		else $error("tick without running oscillator");
endmodule : seat_tick

// ===== core/seat_integ.sv
// Light integration counter: counts base ticks up to the programmed span
`timescale 1ns/100ps
module seat_integ import seat_pkg::*; (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic run,
	input wire logic pause,
	input wire logic tick,
	input wire logic [7:0] als_integration_time,
	output logic done,
	output logic busy
);
	typedef struct packed {
		logic [8:0] cnt;
		logic done;
	} seat_integ_st_t;
	seat_integ_st_t s_q;
	seat_integ_st_t s_d;
	logic [8:0] span;

	assign span = ALS_INTEGRATION_TIME_SPAN - {1'b0, als_integration_time};

	always_comb begin
		s_d = s_q;
		s_d.done = 1'b0;
		if (!run) begin
			s_d.cnt = '0;
		end else if (tick && !pause) begin
			if (s_q.cnt + 9'h001 >= span) begin
				s_d.cnt = '0;
				s_d.done = 1'b1;
			end else begin
				s_d.cnt = s_q.cnt + 9'h001;
			end
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign done = s_q.done;
	assign busy = run;

	a_integ_span_len: assert property (@(posedge clock) disable iff (!arst_n)
		s_q.done |-> $past(s_q.cnt) == $past(span) - 9'h001 && s_q.cnt == '0)
		else $error("integration ended at wrong tick count");
	a_pause_holds_cnt: assert property (@(posedge clock) disable iff (!arst_n)
		(run && pause) ##1 run |-> s_q.cnt == $past(s_q.cnt) && !s_q.done)
		else $error("integration advanced while paused");
endmodule : seat_integ

// ===== core/seat_ctrl.sv
// Function enable and light integration timing registers with APB access
// How it works
// - Beam enable gives LED pin, stops proximity
// - Light keeps converting unless beam enabled and busy
// - Gesture starts on force mode or threshold
// - Proximity interrupt only while its permit set
// - Light interrupt only while its permit set
// - Wait enable bit runs the wait timer
// - Proximity enable bit runs proximity
// - Light enable bit runs light conversion
// - Power on starts oscillator for timers
// - Power off clears beam, proximity, light
// - Integration time is tick times span
// - Integration field resets to all ones
// - Result saturates at smaller limit
`timescale 1ns/100ps
module seat_ctrl import seat_pkg::*; #(
	parameter int TICK_CYC = TICK_CYCLES
) (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic beam_led,
	input wire logic prox_led,
	input wire logic beam_busy,
	input wire logic gesture_force_mode,
	input wire logic [15:0] prox_value,
	input wire logic [15:0] gest_entry_thr,
	input wire logic als_thr_hit,
	input wire logic prox_thr_hit,
	input wire logic [15:0] als_raw,
	output logic led_drive_pin,
	output logic osc_run,
	output logic light_run,
	output logic prox_run,
	output logic wait_run,
	output logic gesture_start,
	output logic light_irq,
	output logic prox_irq,
	output logic als_done,
	output logic [15:0] als_result,
	output logic irq
);
	typedef struct packed {
		logic [7:0] ctrl;
		logic [7:0] als_integration_time;
		logic [EV_N-1:0] irq_en;
		logic [EV_N-1:0] irq_st;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic led;
		logic osc;
		logic light;
		logic prox;
		logic wait_on;
		logic gest;
		logic lirq;
		logic pirq;
		logic done;
		logic [15:0] result;
		logic irq;
	} seat_ctrl_st_t;
	seat_ctrl_st_t s_q;
	seat_ctrl_st_t s_d;
	logic tick;
	logic integ_done;
	logic integ_busy;
	logic setup;
	logic acc;
	logic wr;
	logic [EV_N-1:0] ev;
	logic [EV_N-1:0] clr;

	// Word index match; low address bits must be zero for an aligned word
	function automatic logic at_idx(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
		at_idx = (a == {idx, 2'b00});
	endfunction : at_idx

	// Any mapped register
	function automatic logic mapped(input logic [ADDR_W-1:0] a);
		mapped = at_idx(a, IDX_FUNC_EN) || at_idx(a, IDX_ALS_INTEGRATION_TIME) ||
			at_idx(a, IDX_IRQ_ST) || at_idx(a, IDX_IRQ_EN) ||
			at_idx(a, IDX_IRQ_CLR) || at_idx(a, IDX_ENG_ST) ||
			at_idx(a, IDX_ALS_RES);
	endfunction : mapped

	function automatic logic [15:0] sat_ceiling(input logic [7:0] at);
		logic [8:0] cyc;
		cyc = ALS_INTEGRATION_TIME_SPAN - {1'b0, at};
		if (cyc >= SAT_CYC_LIM) begin
			sat_ceiling = SAT_MAX;
		end else begin
			sat_ceiling = 16'({cyc[5:0], {SAT_SHIFT{1'b0}}});
		end
	endfunction : sat_ceiling

	// Oscillator tick; long period is a parameter so simulation can shorten it
	seat_tick #(
		.TICK_CYC(TICK_CYC)
	) u_tick (
		.clock(clock),
		.arst_n(arst_n),
		.run(s_q.osc),
		.tick(tick)
	);

	seat_integ u_integ (
		.clock(clock),
		.arst_n(arst_n),
		.run(s_q.light),
		.pause(s_q.ctrl[B_BEAM] && beam_busy),
		.tick(tick),
		.als_integration_time(s_q.als_integration_time),
		.done(integ_done),
		.busy(integ_busy)
	);

	// Bus phases; the slave answers in the first access cycle
	assign setup = psel && !penable;
	assign acc = psel && penable && s_q.pready;
	assign wr = acc && pwrite && !s_q.pslverr && pstrb[0];

	// Events that latch into the sticky status
	assign ev[EV_DONE] = s_q.done;
	assign ev[EV_LIRQ] = s_q.lirq;
	assign ev[EV_PIRQ] = s_q.pirq;
	assign ev[EV_GEST] = s_q.gest;
	assign clr = (wr && at_idx(paddr, IDX_IRQ_CLR)) ? pwdata[EV_N-1:0] : '0;

	// Register file, function gating and interrupt collection
	always_comb begin
		s_d = s_q;
		s_d.pready = setup;
		if (setup) begin
			s_d.pslverr = !mapped(paddr);
			s_d.prdata = '0;
			if (at_idx(paddr, IDX_FUNC_EN)) begin
				s_d.prdata[7:0] = s_q.ctrl;
			end
			if (at_idx(paddr, IDX_ALS_INTEGRATION_TIME)) begin
				s_d.prdata[7:0] = s_q.als_integration_time;
			end
			if (at_idx(paddr, IDX_IRQ_ST)) begin
				s_d.prdata[EV_N-1:0] = s_q.irq_st;
			end
			if (at_idx(paddr, IDX_IRQ_EN)) begin
				s_d.prdata[EV_N-1:0] = s_q.irq_en;
			end
			if (at_idx(paddr, IDX_ENG_ST)) begin
				s_d.prdata[6:0] = {beam_busy, integ_busy, s_q.gest, s_q.wait_on,
					s_q.prox, s_q.light, s_q.osc};
			end
			if (at_idx(paddr, IDX_ALS_RES)) begin
				s_d.prdata[15:0] = s_q.result;
			end
		end
		if (wr && at_idx(paddr, IDX_FUNC_EN)) begin
			if (pwdata[B_PON]) begin
				s_d.ctrl = pwdata[7:0];
			end else begin
				s_d.ctrl = pwdata[7:0] & PWR_OFF_KEEP;
			end
		end
		if (wr && at_idx(paddr, IDX_ALS_INTEGRATION_TIME)) begin
			s_d.als_integration_time = pwdata[7:0];
		end
		if (wr && at_idx(paddr, IDX_IRQ_EN)) begin
			s_d.irq_en = pwdata[EV_N-1:0];
		end
		s_d.osc = s_q.ctrl[B_PON];
		s_d.light = s_q.ctrl[B_PON] && s_q.ctrl[B_LIGHT];
		s_d.prox = s_q.ctrl[B_PON] && s_q.ctrl[B_PROX] && !s_q.ctrl[B_BEAM];
		s_d.wait_on = s_q.ctrl[B_PON] && s_q.ctrl[B_WAIT];
		s_d.led = s_q.ctrl[B_BEAM] ? beam_led : (s_q.prox && prox_led);
		s_d.gest = s_q.ctrl[B_PON] && s_q.ctrl[B_GEST] &&
			(gesture_force_mode || prox_value > gest_entry_thr);
		s_d.lirq = s_q.ctrl[B_LIRQ] && s_q.light && als_thr_hit;
		s_d.pirq = s_q.ctrl[B_PIRQ] && s_q.prox && prox_thr_hit;
		s_d.done = integ_done;
		if (integ_done) begin
			if (als_raw > sat_ceiling(s_q.als_integration_time)) begin
				s_d.result = sat_ceiling(s_q.als_integration_time);
			end else begin
				s_d.result = als_raw;
			end
		end
		// Set beats clear so an event in the clearing cycle survives
		s_d.irq_st = (s_q.irq_st & ~clr) | ev;
		s_d.irq = |(s_d.irq_st & s_d.irq_en);
		// power off at any time; judged on the new value so power on can set them
		if (!s_d.ctrl[B_PON]) begin
			s_d.ctrl = s_d.ctrl & (PWR_OFF_KEEP | (8'h01 << B_PON));
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			s_q <= '0;
			s_q.ctrl <= FUNC_EN_RST;
			s_q.als_integration_time <= ALS_INTEGRATION_TIME_RST;
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs come straight from the state register
	assign prdata = s_q.prdata;
	assign pready = s_q.pready;
	assign pslverr = s_q.pslverr;
	assign led_drive_pin = s_q.led;
	assign osc_run = s_q.osc;
	assign light_run = s_q.light;
	assign prox_run = s_q.prox;
	assign wait_run = s_q.wait_on;
	assign gesture_start = s_q.gest;
	assign light_irq = s_q.lirq;
	assign prox_irq = s_q.pirq;
	assign als_done = s_q.done;
	assign als_result = s_q.result;
	assign irq = s_q.irq;

	// Helper: first cycle after reset release
	logic rst_seen_q;
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rst_seen_q <= 1'b0;
		end else begin
			rst_seen_q <= 1'b1;
		end
	end

	sequence s_ctrl_wr;
		wr && at_idx(paddr, IDX_FUNC_EN);
	endsequence

	sequence s_pwr_off_wr;
		s_ctrl_wr ##0 !pwdata[B_PON];
	endsequence

	a_pwr_off_clear: assert property (@(posedge clock) disable iff (!arst_n)
		s_pwr_off_wr |=> !s_q.ctrl[B_BEAM] && !s_q.ctrl[B_PROX] && !s_q.ctrl[B_LIGHT]
		##1 !s_q.light && !s_q.prox)
		else $error("power off did not clear beam, proximity, light");
	a_led_owner_beam: assert property (@(posedge clock) disable iff (!arst_n)
		s_q.ctrl[B_BEAM] |=> s_q.led == $past(beam_led))
		else $error("LED pin not driven by pattern machine");
	a_prox_suppressed: assert property (@(posedge clock) disable iff (!arst_n)
		s_q.ctrl[B_BEAM] |=> !s_q.prox)
		else $error("proximity ran with beam enabled");
	a_gesture_entry: assert property (@(posedge clock) disable iff (!arst_n)
		s_q.gest |-> $past(s_q.ctrl[B_GEST]) && $past(s_q.ctrl[B_PON]) &&
		($past(gesture_force_mode) || $past(prox_value) > $past(gest_entry_thr)))
		else $error("gesture start without its cause");
	a_prox_irq_gate: assert property (@(posedge clock) disable iff (!arst_n)
		s_q.pirq |-> $past(s_q.ctrl[B_PIRQ]) && $past(prox_thr_hit))
		else $error("proximity interrupt without permit");
	a_light_irq_gate: assert property (@(posedge clock) disable iff (!arst_n)
		s_q.lirq |-> $past(s_q.ctrl[B_LIRQ]) && $past(als_thr_hit))
		else $error("light interrupt without permit");
	a_wait_follow: assert property (@(posedge clock) disable iff (!arst_n)
		s_q.ctrl[B_PON] && s_q.ctrl[B_WAIT] |=> s_q.wait_on)
		else $error("wait timer not running");
	a_prox_follow: assert property (@(posedge clock) disable iff (!arst_n)
		s_q.ctrl[B_PON] && s_q.ctrl[B_PROX] && !s_q.ctrl[B_BEAM] |=> s_q.prox)
		else $error("proximity not running");
	a_light_follow: assert property (@(posedge clock) disable iff (!arst_n)
		$rose(s_q.light) |-> $past(s_q.ctrl[B_LIGHT]) && $past(s_q.ctrl[B_PON]))
		else $error("light ran without enable and oscillator");
	a_osc_follow: assert property (@(posedge clock) disable iff (!arst_n)
		s_q.osc == $past(s_q.ctrl[B_PON]))
		else $error("oscillator does not follow power on");
	a_als_integration_time_reset: assert property (@(posedge clock) disable iff (!arst_n)
		!rst_seen_q |-> s_q.als_integration_time == ALS_INTEGRATION_TIME_RST)
		else $error("integration field wrong after reset");
	a_result_sat: assert property (@(posedge clock) disable iff (!arst_n)
		s_q.done |-> s_q.result <= sat_ceiling($past(s_q.als_integration_time)))
		else $error("light result above saturation");
	a_sticky_set_wins: assert property (@(posedge clock) disable iff (!arst_n)
		(|(ev & clr)) |=> |(s_q.irq_st & $past(ev)))
		else $error("event lost in clearing cycle");

	// Slave side of the bus: one access cycle, error only off the map
	sequence s_apb_setup;
		psel && !penable;
	endsequence

	a_ready_after_setup: assert property (@(posedge clock) disable iff (!arst_n)
		s_apb_setup |=> s_q.pready)
		else $error("no ready after setup");
	a_ready_one_cycle: assert property (@(posedge clock) disable iff (!arst_n)
		s_q.pready |=> !s_q.pready)
		else $error("ready stood longer than one cycle");
	a_err_off_map: assert property (@(posedge clock) disable iff (!arst_n)
		s_apb_setup |=> s_q.pslverr == !mapped($past(paddr)))
		else $error("slave error does not match the address map");
	a_strobe_off_kept: assert property (@(posedge clock) disable iff (!arst_n)
		acc && pwrite && !pstrb[0] |=> $stable(s_q.ctrl) && $stable(s_q.als_integration_time))
		else $error("write with low strobe off changed a register");
	a_als_integration_time_write: assert property (@(posedge clock) disable iff (!arst_n)
		wr && at_idx(paddr, IDX_ALS_INTEGRATION_TIME) |=> s_q.als_integration_time == $past(pwdata[7:0]))
		else $error("integration field write lost");
	// Function bits and outputs while power or enables are off
	a_pwr_off_bits: assert property (@(posedge clock) disable iff (!arst_n)
		!s_q.ctrl[B_PON] |-> !s_q.ctrl[B_BEAM] && !s_q.ctrl[B_PROX] && !s_q.ctrl[B_LIGHT])
		else $error("function bit set while power off");
	a_light_needs_en: assert property (@(posedge clock) disable iff (!arst_n)
		!s_q.ctrl[B_LIGHT] |=> !s_q.light)
		else $error("light ran without its enable");
	a_wait_needs_pon: assert property (@(posedge clock) disable iff (!arst_n)
		!s_q.ctrl[B_PON] |=> !s_q.wait_on)
		else $error("wait timer ran without power on");
	a_tick_stops: assert property (@(posedge clock) disable iff (!arst_n)
		!s_q.osc |=> !tick)
		else $error("tick while oscillator stopped");
	a_led_prox_path: assert property (@(posedge clock) disable iff (!arst_n)
		!s_q.ctrl[B_BEAM] |=> s_q.led == ($past(s_q.prox) && $past(prox_led)))
		else $error("LED pin not driven by proximity path");
	// Sticky status keeps a bit until a clear, and a clear drops it unless an event sets it in the same cycle
	a_sticky_hold: assert property (@(posedge clock) disable iff (!arst_n)
		s_q.irq_st[EV_LIRQ] && !clr[EV_LIRQ] |=> s_q.irq_st[EV_LIRQ])
		else $error("sticky bit lost without clear");
	a_clear_drops: assert property (@(posedge clock) disable iff (!arst_n)
		clr[EV_PIRQ] && !ev[EV_PIRQ] |=> !s_q.irq_st[EV_PIRQ])
		else $error("sticky bit survived its clear");
endmodule : seat_ctrl

// ===== verif/seat_engine_model.sv
// Engine-side model: pattern LED, proximity LED and filter pulses
`timescale 1ns/100ps
module seat_engine_model (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic busy_req,
	input wire logic [1:0] hit_req,
	output logic beam_led,
	output logic prox_led,
	output logic beam_busy,
	output logic als_thr_hit,
	output logic prox_thr_hit
);
	logic [1:0] pat_q;
	logic [1:0] hit_q;
	// Free counter keeps the proximity LED moving, and the pattern LED while busy, so a stale select shows
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			pat_q <= 2'h0;
			hit_q <= 2'h0;
		end else begin
			pat_q <= pat_q + 2'h1;
			hit_q <= hit_req;
		end
	end
	// Pattern LED moves only while busy; filter hits leave as single pulses
	assign beam_busy = busy_req;
	assign beam_led = busy_req & pat_q[0];
	assign prox_led = pat_q[1];
	assign als_thr_hit = hit_req[0] & ~hit_q[0];
	assign prox_thr_hit = hit_req[1] & ~hit_q[1];
endmodule : seat_engine_model

// ===== verif/tb_top.sv
// Self-checking bench for the enable and light timing registers
`timescale 1ns/100ps
module tb_top import seat_pkg::*; ;
	localparam int TK = 4;
	localparam logic [9:0] A_EN = {IDX_FUNC_EN, 2'b00};
	localparam logic [9:0] A_AT = {IDX_ALS_INTEGRATION_TIME, 2'b00};
	localparam logic [9:0] A_ST = {IDX_IRQ_ST, 2'b00};
	localparam logic [9:0] A_IE = {IDX_IRQ_EN, 2'b00};
	localparam logic [9:0] A_IC = {IDX_IRQ_CLR, 2'b00};
	localparam logic [9:0] A_RES = {IDX_ALS_RES, 2'b00};
	localparam logic [9:0] A_ENG = {IDX_ENG_ST, 2'b00};
	logic clock, arst_n, psel, penable, pwrite, pready, pslverr, err, busy_req, force_m;
	logic beam_led, prox_led, beam_busy, a_hit, p_hit, pb, pp, led_drive_pin, osc_run;
	logic light_run, prox_run, wait_run, gesture_start, light_irq, prox_irq, als_done, irq;
	logic [9:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] pstrb;
	logic [1:0] hit_req;
	logic [15:0] pval, thr, raw, als_result;
	logic [7:0] tv [8] = '{8'h01, 8'h03, 8'h05, 8'h09, 8'h0F, 8'h0E, 8'hFF, 8'hFE};
	int error_cnt = 0, num_checks = 0, cyc = 0, p0, p, n;
	seat_ctrl #(.TICK_CYC(TK)) uut (.clock, .arst_n, .psel, .penable, .pwrite, .paddr,
		.pwdata, .pstrb, .prdata, .pready, .pslverr, .beam_led, .prox_led, .beam_busy,
		.gesture_force_mode(force_m), .prox_value(pval), .gest_entry_thr(thr),
		.als_thr_hit(a_hit), .prox_thr_hit(p_hit), .als_raw(raw), .led_drive_pin,
		.osc_run, .light_run, .prox_run, .wait_run, .gesture_start, .light_irq,
		.prox_irq, .als_done, .als_result, .irq);
	seat_engine_model eng (.clock, .arst_n, .busy_req, .hit_req, .beam_led, .prox_led,
		.beam_busy, .als_thr_hit(a_hit), .prox_thr_hit(p_hit));
	// 20 MHz clock
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	// LED sources one cycle back, since the pin is registered
	always @(posedge clock) begin
		pb <= beam_led;
		pp <= prox_led;
	end
	// Hang guard, far above the under two thousand cycles the tests need
	always @(posedge clock) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			final_report();
		end
	end
	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : final_report
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			error_cnt++;
			$display("[ERR] %0t seen %h expected %h", $time, s, e);
		end
	endtask : chk
	// One APB transfer; waits for pready with no assumed latency
	task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		// Ready and read data are taken at the rising edge that completes the access
		do begin
			@(posedge clock);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (k >= 20) chk(32'h0, 32'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [9:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task automatic rdck(input logic [9:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd, e);
	endtask : rdck
	task automatic runs(input logic [7:0] v);
		wr(A_EN, {24'h0, v});
		repeat (4) @(negedge clock);
		chk(osc_run, v[0]);
		chk(light_run, v[0] & v[1]);
		chk(prox_run, v[0] & v[2] & ~v[7]);
		chk(wait_run, v[0] & v[3]);
		rdck(A_EN, v[0] ? v : v & 8'h79);
	endtask : runs
	task automatic gest(input logic [7:0] v, input logic f, input logic [15:0] pv,
		input logic [15:0] th, input logic e);
		@(posedge clock);
		force_m <= f;
		pval <= pv;
		thr <= th;
		wr(A_EN, {24'h0, v});
		repeat (4) @(negedge clock);
		chk(gesture_start, e);
	endtask : gest
	task automatic waitd(output int c);
		c = 0;
		do begin
			@(negedge clock);
			c++;
		end while (als_done !== 1'b1 && c < 1000);
		if (c >= 1000) chk(32'h0, 32'h1);
	endtask : waitd
	// settings written with power off, power last
	task automatic integ(input logic [7:0] at, input logic [15:0] rv, input logic [15:0] e);
		wr(A_EN, 32'h0);
		wr(A_AT, {24'h0, at});
		@(posedge clock);
		raw <= rv;
		wr(A_EN, 32'h03);
		waitd(n);
		waitd(p);
		chk(als_result, e);
		rdck(A_RES, {16'h0, e});
	endtask : integ
	task automatic hit(input int w, input logic [31:0] e);
		int c;
		c = 0;
		@(posedge clock);
		hit_req[w] <= 1'b1;
		@(posedge clock);
		hit_req[w] <= 1'b0;
		repeat (4) begin
			@(negedge clock);
			if ((w ? prox_irq : light_irq) === 1'b1) c++;
		end
		chk(c, e);
	endtask : hit
	initial begin
		{arst_n, psel, penable, pwrite, busy_req, force_m} = 6'h00;
		{paddr, pwdata, hit_req, pval, thr, raw} = '0;
		pstrb = 4'hF;
		repeat (10) @(posedge clock);
		arst_n <= 1'b1;
		// Reset values, unmapped place and a write with its low strobe off
		rdck(A_EN, 32'h0);
		rdck(A_AT, 32'hFF);
		chk(err, 1'b0);
		apb(1'b0, 10'h3FC, 32'h0);
		chk(err, 1'b1);
		chk(rd, 32'h0);
		@(posedge clock);
		pstrb <= 4'hE;
		wr(A_AT, 32'h55);
		@(posedge clock);
		pstrb <= 4'hF;
		rdck(A_AT, 32'hFF);
		$display("reset and bus test done");
		foreach (tv[i]) runs(tv[i]);
		$display("enable table test done");
		gest(8'h41, 1'b1, 16'h0000, 16'h0000, 1'b1);
		gest(8'h01, 1'b1, 16'h0000, 16'h0000, 1'b0);
		gest(8'h45, 1'b0, 16'h0010, 16'h0005, 1'b1);
		gest(8'h45, 1'b0, 16'h0005, 16'h0005, 1'b0);
		$display("gesture test done");
		integ(8'hFF, 16'hFFFF, 16'h0400);
		p0 = p;
		integ(8'hFE, 16'hFFFF, 16'h0800);
		chk(p - p0, TK);
		integ(8'hF6, 16'hFFFF, 16'h2800);
		chk(p - p0, 9 * TK);
		integ(8'hC1, 16'hFFFF, 16'hFC00);
		integ(8'hC0, 16'hFFFF, 16'hFFFF);
		integ(8'hFF, 16'h0123, 16'h0123);
		$display("integration test done");
		// beam takes the LED pin and pauses light while busy
		wr(A_EN, 32'h0);
		@(posedge clock);
		busy_req <= 1'b1;
		wr(A_EN, 32'h87);
		repeat (3) @(negedge clock);
		n = 0;
		repeat (30) begin
			@(negedge clock);
			if (als_done === 1'b1) n++;
			chk(led_drive_pin, pb);
		end
		chk(n, 0);
		chk(prox_run, 1'b0);
		rdck(A_ENG, 32'h63);
		@(posedge clock);
		busy_req <= 1'b0;
		waitd(n);
		chk(n < 30, 1'b1);
		wr(A_EN, 32'h07);
		repeat (3) @(negedge clock);
		chk(prox_run, 1'b1);
		repeat (8) begin
			@(negedge clock);
			chk(led_drive_pin, pp);
		end
		$display("beam test done");
		// Interrupt permits, sticky status, mask and clear
		wr(A_IE, 32'h6);
		hit(0, 0);
		hit(1, 0);
		chk(irq, 1'b0);
		wr(A_EN, 32'h37);
		hit(0, 1);
		hit(1, 1);
		repeat (2) @(negedge clock);
		chk(irq, 1'b1);
		apb(1'b0, A_ST, 32'h0);
		chk(rd & 32'h6, 32'h6);
		wr(A_IE, 32'h0);
		repeat (2) @(negedge clock);
		chk(irq, 1'b0);
		wr(A_IE, 32'h6);
		repeat (2) @(negedge clock);
		chk(irq, 1'b1);
		wr(A_IC, 32'h6);
		wr(A_ST, 32'hFF);
		repeat (2) @(negedge clock);
		chk(irq, 1'b0);
		apb(1'b0, A_ST, 32'h0);
		chk(rd & 32'h6, 32'h0);
		rdck(A_IC, 32'h0);
		// Clears every three cycles against done every four: one meets an event
		repeat (4) wr(A_IC, 32'h1);
		$display("interrupt test done");
		// Reset in mid-run brings every setting back to its reset value
		wr(A_AT, 32'h80);
		@(posedge clock);
		arst_n <= 1'b0;
		repeat (3) @(posedge clock);
		arst_n <= 1'b1;
		@(negedge clock);
		chk({osc_run, light_run, irq, led_drive_pin}, 4'h0);
		rdck(A_EN, 32'h0);
		rdck(A_AT, 32'hFF);
		rdck(A_ST, 32'h0);
		$display("mid-run reset test done");
		final_report();
	end
endmodule : tb_top
